/* File: pkg/iss_pkg.sv */
// Package for the isolated switch serial control block.
// Assumes one system clock ref_clk and a separate serial link clock.
`default_nettype none

package iss_pkg;
	localparam int CHANNELS = 8;
	localparam int CNT_W = 3;
	localparam logic [7:0] SWITCH_RESET = 8'h00;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
	localparam logic [1:0] SYNC_RESET = 2'h0;
	localparam logic [2:0] TOGGLE_SYNC_RESET = 3'h0;
	localparam int STABLE_CYCLES = 4;
	localparam logic [2:0] STABLE_COUNT = 3'(STABLE_CYCLES);

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} iss_word_s;

	typedef enum logic [1:0] {
		ISS_POWERUP,
		ISS_OFF,
		ISS_RUN
	} iss_state_e;
endpackage : iss_pkg

`default_nettype wire

/* File: verilog/iss_sync.sv */
// Two-stage synchroniser for a level from another clock domain.
// Assumes the destination clock is the clk port.
`default_nettype none

module iss_sync
	import iss_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	logic [1:0] stage;
	logic [1:0] next_stage;

	always_comb begin
		next_stage = {stage[0], din};
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stage <= SYNC_RESET;
		end else begin
			stage <= next_stage;
		end
	end

	// Only the second stage leaves the module
	assign dout = stage[1];
endmodule : iss_sync

`default_nettype wire

/* File: verilog/iss_serial_ctrl.sv */
// Serial control logic of an isolated eight-channel high-side switch.
// Assumes sclk from the master, held high across every chip select edge.
// Summary of operation
// - Disable low switches all outputs off at once, without clock.
// - Disable low also clears the received input registers.
// - After disable releases, outputs stay off until a new word arrives.
// - Serial interface active only while chip select is low.
// - Data input sampled on each rising serial clock edge.
// - Data output updated after each falling serial clock edge.
// - Data output driven only while chip select low, else released.
// - Fault flag low when any channel overtemperature detector is set.
// - Fault flag low on low driver supply, high only when no detector is set and the supply is good.
// - Each channel has its own output latch.
// - Data bit one turns channel on, zero turns it off.
// - Chip select rising copies shifted bits into output latches.
// - Outputs disabled until the input logic is stable after power up.
// - Data moves most significant bit first, both directions.
// - Clock pulses counted; transfer only on a multiple of eight.
// - With chip select low the block is a plain shift register.
`default_nettype none

module iss_serial_ctrl
	import iss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	input wire logic output_disable_n,
	input wire logic [7:0] overtemp,
	input wire logic driver_supply_low,
	output logic [7:0] switch_out,
	output logic fault_flag_n
);
	// ==========================================================
	// Link side, on the serial clock
	// ==========================================================
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic so_bit;
	logic next_so_bit;
	logic link_clear;

	// Disable or deselect clears the link state without a clock edge
	assign link_clear = ~output_disable_n | chip_select_n;

	always_comb begin
		next_shift = {shift[6:0], serial_in};
		next_count = count + 3'h1;
	end

	always_ff @(posedge sclk or posedge link_clear) begin
		if (link_clear) begin
			shift <= SHIFT_RESET;
			count <= CNT_RESET;
		end else begin
			shift <= next_shift;
			count <= next_count;
		end
	end

	// Output bit moves on the falling edge; cleared to zero while deselected
	always_comb begin
		next_so_bit = shift[7];
	end

	always_ff @(negedge sclk or posedge link_clear) begin
		if (link_clear) begin
			so_bit <= 1'b0;
		end else begin
			so_bit <= next_so_bit;
		end
	end

	// Before the first falling edge the MSB is shown directly
	logic seen_fall;
	logic next_seen_fall;

	always_comb begin
		next_seen_fall = 1'b1;
	end

	always_ff @(negedge sclk or posedge link_clear) begin
		if (link_clear) begin
			seen_fall <= 1'b0;
		end else begin
			seen_fall <= next_seen_fall;
		end
	end

	assign serial_out = seen_fall ? so_bit : shift[7];
	assign serial_out_oe = ~chip_select_n;

	// ==========================================================
	// Hold copies, on the serial clock
	// ==========================================================
	// The link registers clear as soon as chip select rises, which races
	// the capture edge; these copies keep the word until it is taken
	logic [7:0] shift_hold;
	logic [7:0] next_shift_hold;

	logic [CNT_W-1:0] count_hold;
	logic [CNT_W-1:0] next_count_hold;

	logic any_clk;
	logic next_any_clk;

	always_comb begin
		next_shift_hold = shift_hold;
		next_count_hold = count_hold;
		next_any_clk = any_clk;
		// Edges while deselected are ignored
		if (!chip_select_n) begin
			next_shift_hold = next_shift;
			next_count_hold = next_count;
			next_any_clk = 1'b1;
		end
	end

	// Disable clears the copies without a clock, like the word itself
	always_ff @(posedge sclk or negedge output_disable_n) begin
		if (!output_disable_n) begin
			shift_hold <= SHIFT_RESET;
			count_hold <= CNT_RESET;
			any_clk <= 1'b0;
		end else begin
			shift_hold <= next_shift_hold;
			count_hold <= next_count_hold;
			any_clk <= next_any_clk;
		end
	end

	// ==========================================================
	// Word capture, on the rising chip select
	// ==========================================================
	// The toggle is the only bit that crosses; word and its flag are
	// settled two ref_clk edges before the toggle is seen there
	logic [7:0] word;
	logic [7:0] next_word;

	logic word_ok;
	logic next_word_ok;

	logic word_tog;
	logic next_word_tog;

	// sclk is high at this edge by the master's duty
	always_comb begin
		next_word = shift_hold;
		next_word_ok = (count_hold == CNT_RESET) && any_clk;
		next_word_tog = ~word_tog;
	end

	// Limitation: select rises closer together than about one ref_clk
	// period can hide a toggle from the system side
	always_ff @(posedge chip_select_n or negedge output_disable_n) begin
		if (!output_disable_n) begin
			word <= SWITCH_RESET;
			word_ok <= 1'b0;
			word_tog <= 1'b0;
		end else begin
			word <= next_word;
			word_ok <= next_word_ok;
			word_tog <= next_word_tog;
		end
	end

	// ==========================================================
	// System side, on ref_clk
	// ==========================================================
	logic tog_s;
	logic dis_s;
	iss_sync u_tog_sync (
		.clk(ref_clk),
		.reset(reset),
		.din(word_tog),
		.dout(tog_s)
	);
	iss_sync u_dis_sync (
		.clk(ref_clk),
		.reset(reset),
		.din(output_disable_n),
		.dout(dis_s)
	);

	iss_state_e state;
	iss_state_e next_state;
	logic [2:0] stable;
	logic [2:0] next_stable;
	logic tog_d;
	logic [7:0] latch;
	logic [7:0] next_latch;

	// Word is stable: its toggle crossed two stages after capture
	always_comb begin
		next_state = state;
		next_stable = stable;
		next_latch = latch;
		case (state)
			ISS_POWERUP: begin
				if (stable == STABLE_COUNT) begin
					next_state = ISS_OFF;
				end else begin
					next_stable = stable + 3'h1;
				end
			end
			ISS_OFF: begin
				next_latch = SWITCH_RESET;
				if (dis_s && tog_s != tog_d && word_ok) begin
					next_latch = word;
					next_state = ISS_RUN;
				end
			end
			ISS_RUN: begin
				if (!dis_s) begin
					next_latch = SWITCH_RESET;
					next_state = ISS_OFF;
				end else if (tog_s != tog_d && word_ok) begin
					next_latch = word;
				end
			end
			default: begin
				next_state = ISS_POWERUP;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= ISS_POWERUP;
			stable <= 3'h0;
			latch <= SWITCH_RESET;
			tog_d <= 1'b0;
		end else begin
			state <= next_state;
			stable <= next_stable;
			latch <= next_latch;
			tog_d <= tog_s;
		end
	end

	// Disable gates outputs combinationally, no clock needed
	assign switch_out = latch & {CHANNELS{output_disable_n}};

	// ==========================================================
	// Fault flag, on ref_clk
	// ==========================================================
	// Detector levels come from the output side, so each passes two stages first
	logic [CHANNELS-1:0] overtemp_s;
	logic supply_low_s;
	logic fault;
	logic next_fault;

	// One synchroniser per channel keeps each detector independent
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_temp_sync
		iss_sync u_temp_sync (
			.clk(ref_clk),
			.reset(reset),
			.din(overtemp[ch]),
			.dout(overtemp_s[ch])
		);
	end

	iss_sync u_supply_sync (
		.clk(ref_clk),
		.reset(reset),
		.din(driver_supply_low),
		.dout(supply_low_s)
	);

	// Any one channel's detector is enough; the flag is the inverse of their OR with the supply
	// Limitation: a detector pulse shorter than a ref_clk period can be missed
	always_comb begin
		next_fault = ~(|overtemp_s | supply_low_s);
	end

	// Reset value is high so no false fault shows while reset is held
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fault <= 1'b1;
		end else begin
			fault <= next_fault;
		end
	end

	// Flag reads high in normal operation
	assign fault_flag_n = fault;
endmodule : iss_serial_ctrl

`default_nettype wire

/* File: tb/iss_serial_ctrl_properties.sv */
// Checker of the serial switch control block.
// Assumes a bind to iss_serial_ctrl.
`default_nettype none
module iss_serial_ctrl_properties (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic output_disable_n,
	input wire logic [7:0] overtemp,
	input wire logic driver_supply_low,
	input wire logic [7:0] switch_out,
	input wire logic fault_flag_n
);
	logic [3:0] since_cs;
	logic [3:0] rises;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ====
	// Cycles since select rose, saturating
	always_ff @(posedge ref_clk) begin
		if (reset) since_cs <= 4'hf;
		else if ($rose(chip_select_n)) since_cs <= 4'h0;
		else if (since_cs != 4'hf) since_cs <= since_cs + 4'h1;
	end
	// Rising serial clocks since select fell, saturating
	always_ff @(posedge sclk or posedge chip_select_n) begin
		if (chip_select_n) rises <= 4'h0;
		else if (rises != 4'hf) rises <= rises + 4'h1;
	end
	a_disable_off: assert property (
		!output_disable_n |-> switch_out == 8'h00) else $error("on while disabled");
	a_release_off: assert property (
		$rose(output_disable_n) |-> (switch_out == 8'h00)[*4]) else $error("on after release");
	a_oe_select: assert property (
		serial_out_oe == !chip_select_n) else $error("bad enable");
	a_fault_temp: assert property (
		(|overtemp)[*4] |-> !fault_flag_n) else $error("no temp fault");
	a_fault_supply: assert property (
		driver_supply_low[*4] |-> !fault_flag_n) else $error("no supply fault");
	a_fault_clear: assert property (
		(overtemp == 8'h00 && !driver_supply_low)[*4] |-> fault_flag_n) else $error("stuck fault");
	a_word_timing: assert property (
		$changed(switch_out) && output_disable_n && $past(output_disable_n) |-> since_cs < 4'h7)
		else $error("late or stray update");
	a_out_stable: assert property (@(posedge sclk) disable iff (chip_select_n)
		rises >= 4'h8 |-> serial_out == $past(serial_in, 8))
		else $error("shifted out bit out of order");
endmodule : iss_serial_ctrl_properties
bind iss_serial_ctrl iss_serial_ctrl_properties iss_serial_ctrl_properties_i (
	.ref_clk(ref_clk), .reset(reset), .sclk(sclk), .chip_select_n(chip_select_n),
	.serial_in(serial_in),
	.serial_out(serial_out), .serial_out_oe(serial_out_oe),
	.output_disable_n(output_disable_n), .overtemp(overtemp),
	.driver_supply_low(driver_supply_low), .switch_out(switch_out),
	.fault_flag_n(fault_flag_n));
`default_nettype wire

/* File: tb/iss_master_model.sv */
// Serial master model; clock runs only inside frames.
// Assumes the bench calls frame and reads rx.
`default_nettype none
module iss_master_model (
	output logic sclk,
	output logic chip_select_n,
	output logic serial_in,
	input wire logic serial_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rx;
	initial begin
		sclk = 1'b1;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
	end
	// ====
	// Clock held high across select edges
	task automatic frame(input logic [15:0] w, input int n);
		#7 chip_select_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#15 sclk = 1'b0;
			serial_in = w[i];
			#15 sclk = 1'b1;
			rx = {rx[14:0], serial_out};
		end
		#15 chip_select_n = 1'b1;
		serial_in = ~serial_in;
	endtask : frame
endmodule : iss_master_model
`default_nettype wire

/* File: tb/iss_serial_ctrl_bench.sv */
// Self-checking bench of the serial switch control block.
// Assumes the master model drives the link side.
`default_nettype none
module iss_serial_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic output_disable_n = 1'b1;
	logic driver_supply_low = 1'b0;
	logic [7:0] overtemp = 8'h00;
	logic sclk, chip_select_n, serial_in, serial_out, serial_out_oe, fault_flag_n;
	logic [7:0] switch_out, want;
	logic [15:0] w;
	int fails = 0;
	int total_checks = 0;
	always #10 ref_clk = ~ref_clk;
	iss_serial_ctrl iss_serial_ctrl_i (.ref_clk(ref_clk), .reset(reset), .sclk(sclk),
		.chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .output_disable_n(output_disable_n),
		.overtemp(overtemp), .driver_supply_low(driver_supply_low),
		.switch_out(switch_out), .fault_flag_n(fault_flag_n));
	iss_master_model iss_master_model_i (.sclk(sclk), .chip_select_n(chip_select_n),
		.serial_in(serial_in), .serial_out(serial_out));
	// ====
	// Shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check
	// Word taken only on a nonzero multiple of eight clocks
	function automatic logic [7:0] expect_word(logic [15:0] v, int n, logic [7:0] prev);
		return (n > 0 && n % 8 == 0) ? v[7:0] : prev;
	endfunction : expect_word
	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cycles
	task automatic send(input logic [15:0] v, input int n);
		want = expect_word(v, n, want);
		iss_master_model_i.frame(v, n);
		cycles(8);
		#1 check(switch_out, want);
	endtask : send
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// ====
	// Tests
	initial begin
		void'($urandom(32'h18d9));
		want = 8'h00;
		cycles(10);
		reset <= 1'b0;
		#1 check(switch_out, 8'h00);
		cycles(8);
		send(16'h0080, 8);
		send(16'h0001, 8);
		for (int i = 0; i < 6; i++) send(16'($urandom), 8);
		$display("test words done");
		send(16'h00a5, 7);
		send(16'h015a, 9);
		send(16'h00ff, 0);
		w = 16'($urandom);
		send(w, 16);
		check(iss_master_model_i.rx[7:0], w[15:8]);
		$display("test counts done");
		send(16'h00c3, 8);
		@(posedge ref_clk);
		output_disable_n <= 1'b0;
		#1 check(switch_out, 8'h00);
		cycles(3);
		output_disable_n <= 1'b1;
		want = 8'h00;
		cycles(4);
		#1 check(switch_out, 8'h00);
		w = 16'($urandom);
		send(w, 16);
		check(iss_master_model_i.rx[15:8], 8'h00);
		$display("test disable done");
		for (int i = 0; i < 9; i++) begin
			@(posedge ref_clk);
			overtemp <= 8'h01 << i;
			driver_supply_low <= (i == 8);
			cycles(5);
			#1 check({7'h00, fault_flag_n}, 8'h00);
			@(posedge ref_clk);
			overtemp <= 8'h00;
			driver_supply_low <= 1'b0;
			cycles(5);
			#1 check({7'h00, fault_flag_n}, 8'h01);
		end
		$display("test fault done");
		stop_test();
	end
	initial begin
		#100000;
		fails++;
		stop_test();
	end
endmodule : iss_serial_ctrl_bench
`default_nettype wire
